// ==== logic/pvl_palette_ram.sv ====
// Palette memory, 256 colour words, registered read data
`timescale 1ns/10ps
module pvl_palette_ram
    import pvl_pkg::*;
#(
    parameter int WIDTH   = 24,
    parameter int ENTRIES = 256,
    parameter int AW      = 8
) (
    input  wire logic             clock,
    input  wire logic             wr_en,
    input  wire logic [AW-1:0]    wr_addr,
    input  wire logic [WIDTH-1:0] wr_data,
    input  wire logic [AW-1:0]    rd_addr,
    output logic      [WIDTH-1:0] rd_data_q
);

    logic [WIDTH-1:0] mem [ENTRIES];

    always_ff @(posedge clock) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
    end

    // No reset on a memory read port; contents are software defined
    always_ff @(posedge clock) begin
        rd_data_q <= mem[rd_addr];
    end

endmodule : pvl_palette_ram

// ==== logic/pvl_pixel_front.sv ====
// Pixel input latch, palette and overlay select, video level encoder
//
// The register offsets and the plain strobed port were left to the implementer.
`timescale 1ns/10ps
module pvl_pixel_front
    import pvl_pkg::*;
#(
    parameter int IDX_W = PVL_IDX_W,
    parameter int OVL_W = PVL_OVL_W,
    parameter int COL_W = PVL_COL_W
) (
    input  wire logic                 clock,
    input  wire logic                 reset_n,
    // Pixel inputs from frame buffer
    input  wire logic [IDX_W-1:0]     pixel_index,
    input  wire logic [OVL_W-1:0]     overlay_select,
    input  wire logic                 sync_n,
    input  wire logic                 blank_n,
    input  wire logic                 pedestal_sel,
    input  wire logic                 scale_50,
    input  wire logic                 sync_enable,
    input  wire logic                 in_valid,
    output logic                      in_ready,
    // Register port
    input  wire logic [3:0]           reg_addr,
    input  wire logic [7:0]           reg_wdata,
    input  wire logic                 reg_write,
    input  wire logic                 reg_read,
    output logic      [7:0]           reg_rdata,
    // Output stream
    output logic                      out_valid,
    input  wire logic                 out_ready,
    output logic      [COL_W-1:0]     red,
    output logic      [COL_W-1:0]     green,
    output logic      [COL_W-1:0]     blue,
    output logic      [PVL_LVL_W-1:0] level,
    output logic      [PVL_CUR_W-1:0] iout_red,
    output logic      [PVL_CUR_W-1:0] iout_green,
    output logic      [PVL_CUR_W-1:0] iout_blue
);

    localparam int CW = 3 * COL_W;

    // ************************************************************
    // Input synchronisers and pixel latch
    // ************************************************************
    logic [IDX_W-1:0] idx_m_q, idx_s_q, idx_q;
    logic [OVL_W-1:0] ovl_m_q, ovl_s_q, ovl_q;
    logic [4:0]       ctl_m_q, ctl_s_q;
    logic             sync_n_q, blank_n_q, lat_vld_q;
    logic             ped_m_q, ped_s_q, ped_q, scl_q, sen_q;
    logic             adv;

    always_ff @(posedge clock) begin
        if (!reset_n) begin
            idx_m_q <= '0;
            idx_s_q <= '0;
            ovl_m_q <= '0;
            ovl_s_q <= '0;
            ctl_m_q <= 5'h03;
            ctl_s_q <= 5'h03;
        end else begin
            idx_m_q <= pixel_index;
            idx_s_q <= idx_m_q;
            ovl_m_q <= overlay_select;
            ovl_s_q <= ovl_m_q;
            ctl_m_q <= {in_valid, sync_enable, scale_50, sync_n, blank_n};
            ctl_s_q <= ctl_m_q;
        end
    end

    // Pedestal strap is a pin too, so it gets the same two flops
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            ped_m_q <= 1'b0;
            ped_s_q <= 1'b0;
        end else begin
            ped_m_q <= pedestal_sel;
            ped_s_q <= ped_m_q;
        end
    end

    // Static straps, taken after the synchroniser
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            ped_q <= 1'b0;
            scl_q <= 1'b0;
            sen_q <= 1'b1;
        end else begin
            ped_q <= ped_s_q;
            scl_q <= ctl_s_q[2];
            sen_q <= ctl_s_q[3];
        end
    end

    // All five inputs captured on the same edge
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            idx_q     <= '0;
            ovl_q     <= '0;
            sync_n_q  <= 1'b1;
            blank_n_q <= 1'b0;
            lat_vld_q <= 1'b0;
        end else if (adv) begin
            idx_q     <= idx_s_q;
            ovl_q     <= ovl_s_q;
            sync_n_q  <= ctl_s_q[1];
            blank_n_q <= ctl_s_q[0];
            lat_vld_q <= ctl_s_q[4];
        end
    end

    // ************************************************************
    // Register port
    // ************************************************************
    logic [IDX_W-1:0] waddr_q, mask_q;
    logic [COL_W-1:0] r_q, g_q;
    logic [CW-1:0]    ovl_col_q [16];
    logic             pal_we;
    logic [7:0]       rdata_d;

    // Colour write completes on blue, then address steps
    assign pal_we = reg_write && reg_addr == PVL_REG_PAL_B;

    // Address register steps after each blue write
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            waddr_q <= '0;
        end else if (reg_write && reg_addr == PVL_REG_ADDR) begin
            waddr_q <= reg_wdata;
        end else if (reg_write && (reg_addr == PVL_REG_PAL_B || reg_addr == PVL_REG_OVL_B)) begin
            waddr_q <= waddr_q + 8'h01;
        end
    end

    // Mask may change at any time; it acts on the next lookup
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            mask_q <= PVL_MASK_RST;
        end else if (reg_write && reg_addr == PVL_REG_MASK) begin
            mask_q <= reg_wdata;
        end
    end

    // Red and green wait here until blue completes the word
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            r_q <= '0;
            g_q <= '0;
        end else if (reg_write) begin
            case (reg_addr)
                PVL_REG_PAL_R, PVL_REG_OVL_R: r_q <= reg_wdata;
                PVL_REG_PAL_G, PVL_REG_OVL_G: g_q <= reg_wdata;
                default: ;
            endcase
        end
    end

    // Overlay slot 0 is reserved; its word is staged but never selected
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            for (int i = 0; i < 16; i++) begin
                ovl_col_q[i] <= '0;
            end
        end else if (reg_write && reg_addr == PVL_REG_OVL_B) begin
            ovl_col_q[waddr_q[3:0]] <= {r_q, g_q, reg_wdata};
        end
    end

    always_comb begin
        case (reg_addr)
            PVL_REG_ADDR:   rdata_d = waddr_q;
            PVL_REG_MASK:   rdata_d = mask_q;
            PVL_REG_STATUS: rdata_d = {3'h0, sen_q, scl_q, ped_q, blank_n_q, sync_n_q};
            default:        rdata_d = 8'h00;
        endcase
    end

    always_ff @(posedge clock) begin
        if (!reset_n) begin
            reg_rdata <= 8'h00;
        end else if (reg_read) begin
            reg_rdata <= rdata_d;
        end else begin
            reg_rdata <= 8'h00;
        end
    end

    // ************************************************************
    // Palette lookup
    // ************************************************************
    logic [IDX_W-1:0] look_idx, stg_idx_q, rd_idx;
    logic [CW-1:0]    pal_word, ovl_word_q;
    logic             ovl_hit_q, blank_n_p, sync_n_p, vld_p;

    assign look_idx = idx_q & mask_q;
    // While stalled the RAM rereads the staged pixel, so its word stays aligned
    assign rd_idx   = adv ? look_idx : stg_idx_q;

    pvl_palette_ram #(
        .WIDTH   (CW),
        .ENTRIES (PVL_ENTRIES),
        .AW      (IDX_W)
    ) u_ram (
        .clock     (clock),
        .wr_en     (pal_we),
        .wr_addr   (waddr_q),
        .wr_data   ({r_q, g_q, reg_wdata}),
        .rd_addr   (rd_idx),
        .rd_data_q (pal_word)
    );

    // Stage aligned with the RAM read register
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            ovl_hit_q  <= 1'b0;
            ovl_word_q <= '0;
            blank_n_p  <= 1'b0;
            sync_n_p   <= 1'b1;
            vld_p      <= 1'b0;
            stg_idx_q  <= '0;
        end else if (adv) begin
            ovl_hit_q  <= ovl_q != '0;
            ovl_word_q <= ovl_col_q[ovl_q];
            blank_n_p  <= blank_n_q;
            sync_n_p   <= sync_n_q;
            vld_p      <= lat_vld_q;
            stg_idx_q  <= look_idx;
        end
    end

    // ************************************************************
    // Level encoding and currents
    // ************************************************************
    logic [CW-1:0]          col;
    logic [PVL_LVL_W-1:0]   lvl;
    logic [PVL_CUR_W-1:0]   cur [3];
    logic [PVL_CUR_W-1:0]   i_white, i_black, i_blank, i_sync;

    // Overlay wins over index; blank wins over both
    assign col = !blank_n_p ? '0 : (ovl_hit_q ? ovl_word_q : pal_word);

    always_comb begin
        if (scl_q) begin
            i_white = sen_q ? PVL_I_WHITE_50E : PVL_I_WHITE_50D;
            i_blank = sen_q ? PVL_I_BLANK_50 : 12'h000;
            i_sync  = sen_q ? PVL_I_BLANK_50 : 12'h000;
        end else begin
            i_white = ped_q ? PVL_I_WHITE_75S : PVL_I_WHITE_75;
            i_blank = PVL_I_BLANK_75;
            i_sync  = PVL_I_SYNC_75;
        end
        i_black = (ped_q && !scl_q) ? PVL_I_BLACK_75S : i_blank;
    end

    always_comb begin
        if (!blank_n_p) begin
            lvl = sync_n_p ? PVL_LVL_BLANK : PVL_LVL_SYNC;
        end else if (!sync_n_p) begin
            lvl = PVL_LVL_SYNC;
        end else if (col == '1) begin
            lvl = PVL_LVL_WHITE;
        end else if (col == '0) begin
            lvl = PVL_LVL_BLACK;
        end else begin
            lvl = PVL_LVL_DATA;
        end
    end

    // Linear data span from black to white, sync offset then removed
    generate
        for (genvar c = 0; c < 3; c++) begin : g_ch
            logic [COL_W-1:0]     dv;
            logic [2*PVL_CUR_W-1:0] prod;
            logic [PVL_CUR_W-1:0] base;
            assign dv   = col[(2-c)*COL_W +: COL_W];
            assign prod = (2*PVL_CUR_W)'(dv) * (2*PVL_CUR_W)'(i_white - i_black);
            assign base = !blank_n_p ? i_blank
                        : i_black + PVL_CUR_W'(prod / (2*PVL_CUR_W)'(8'hFF));
            assign cur[c] = sync_n_p ? base
                          : (base > i_sync ? base - i_sync : 12'h000);
        end
    endgenerate

    // ************************************************************
    // Two-entry output buffer
    // ************************************************************
    logic [CW+PVL_LVL_W+3*PVL_CUR_W-1:0] bd_q [2];
    logic [1:0] cnt_q;
    logic       rd_q, wr_q, push, pop;

    // Latch and stage stall when the buffer is full; the synchroniser flops keep shifting and can drop a word
    assign in_ready  = cnt_q != 2'h2;
    assign adv       = in_ready;
    assign push      = adv && vld_p;
    assign out_valid = cnt_q != 2'h0;
    assign pop       = out_valid && out_ready;

    // Fill count; in_ready drops at two so nothing lands in a full buffer
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            cnt_q <= 2'h0;
        end else begin
            cnt_q <= cnt_q + {1'b0, push} - {1'b0, pop};
        end
    end

    always_ff @(posedge clock) begin
        if (!reset_n) begin
            wr_q    <= 1'b0;
            bd_q[0] <= '0;
            bd_q[1] <= '0;
        end else if (push) begin
            bd_q[wr_q] <= {col, lvl, cur[0], cur[1], cur[2]};
            wr_q       <= ~wr_q;
        end
    end

    always_ff @(posedge clock) begin
        if (!reset_n) begin
            rd_q <= 1'b0;
        end else if (pop) begin
            rd_q <= ~rd_q;
        end
    end

    assign {red, green, blue, level, iout_red, iout_green, iout_blue} = bd_q[rd_q];

endmodule : pvl_pixel_front

// ==== logic/pvl_pkg.sv ====
// Package of constants and types for the pixel input and video level select block
package pvl_pkg;

    // ************************************************************
    // Widths
    // ************************************************************
    localparam int PVL_IDX_W   = 8;
    localparam int PVL_OVL_W   = 4;
    localparam int PVL_COL_W   = 8;
    localparam int PVL_ENTRIES = 256;
    localparam int PVL_LVL_W   = 5;
    localparam int PVL_CUR_W   = 12;

    // ************************************************************
    // Reset value and data codes
    // ************************************************************
    localparam logic [7:0] PVL_MASK_RST = 8'hFF;
    localparam logic [7:0] PVL_DATA_WHITE = 8'hFF;
    localparam logic [7:0] PVL_DATA_BLACK = 8'h00;

    // ************************************************************
    // Register offsets (port address)
    // ************************************************************
    localparam logic [3:0] PVL_REG_ADDR   = 4'h0;
    localparam logic [3:0] PVL_REG_PAL_R  = 4'h1;
    localparam logic [3:0] PVL_REG_PAL_G  = 4'h2;
    localparam logic [3:0] PVL_REG_PAL_B  = 4'h3;
    localparam logic [3:0] PVL_REG_MASK   = 4'h4;
    localparam logic [3:0] PVL_REG_OVL_R  = 4'h5;
    localparam logic [3:0] PVL_REG_OVL_G  = 4'h6;
    localparam logic [3:0] PVL_REG_OVL_B  = 4'h7;
    localparam logic [3:0] PVL_REG_STATUS = 4'h8;

    // ************************************************************
    // Output currents in units of 10 uA
    // ************************************************************
    localparam logic [11:0] PVL_I_WHITE_75S = 12'hA6B; // 26.67 mA
    localparam logic [11:0] PVL_I_BLACK_75S = 12'h389; // 9.05 mA
    localparam logic [11:0] PVL_I_BLANK_75  = 12'h2FA; // 7.62 mA
    localparam logic [11:0] PVL_I_SYNC_75   = 12'h2FA; // 40 IRE, 7.62 mA
    localparam logic [11:0] PVL_I_WHITE_75  = 12'h9DC; // 25.24 mA
    localparam logic [11:0] PVL_I_WHITE_50E = 12'h7F4; // 20.36 mA
    localparam logic [11:0] PVL_I_BLANK_50  = 12'h263; // 6.11 mA
    localparam logic [11:0] PVL_I_WHITE_50D = 12'h591; // 14.25 mA

    // ************************************************************
    // Level codes
    // ************************************************************
    typedef enum logic [4:0] {
        PVL_LVL_SYNC  = 5'h01,
        PVL_LVL_BLANK = 5'h02,
        PVL_LVL_BLACK = 5'h04,
        PVL_LVL_DATA  = 5'h08,
        PVL_LVL_WHITE = 5'h10
    } pvl_level_t;

endpackage : pvl_pkg

// ==== test/pixel_input_video_level_select_tb.sv ====
// Testbench of the pixel front end
`timescale 1ns/10ps
`define CHK(nm, e, g) tests_run++; if ((g) !== (e)) begin \
    $display("MISMATCH %s exp %0h got %0h", nm, e, g); n_fail++; end
module pixel_input_video_level_select_tb
    import pvl_pkg::*;
;
    logic clock = 0, reset_n = 0, pedestal_sel = 1, scale_50 = 0, sync_enable = 1;
    logic out_ready = 1, req = 0, bad_ok = 0, px_sync_n = 1, px_blank_n = 1;
    logic reg_write = 0, reg_read = 0, in_valid, sync_n, blank_n, in_ready, out_valid;
    logic [7:0]  px_idx = 0, reg_wdata = 0, pixel_index, reg_rdata, red, green, blue;
    logic [3:0]  px_ovl = 0, reg_addr = 0, overlay_select;
    logic [4:0]  level;
    logic [11:0] iout_red, iout_green, iout_blue;
    int n_fail = 0, tests_run = 0;
    // Data word 12h on red, truncated like the linear ramp
    localparam logic [11:0] I_D12 = 12'(32'(PVL_I_BLACK_75S)
        + 32'h12 * 32'(PVL_I_WHITE_75S - PVL_I_BLACK_75S) / 255);
    function automatic logic [11:0] lin75(input logic [7:0] d);
        return 12'(32'(PVL_I_BLACK_75S) + 32'(d) * 32'(PVL_I_WHITE_75S - PVL_I_BLACK_75S) / 255);
    endfunction : lin75
    always #2 clock = ~clock;
    pvl_fb_model i_fb (.clock(clock), .reset_n(reset_n), .req(req), .px_idx(px_idx),
        .px_ovl(px_ovl), .px_sync_n(px_sync_n), .px_blank_n(px_blank_n), .bad_ok(bad_ok),
        .in_ready(in_ready), .pixel_index(pixel_index), .overlay_select(overlay_select),
        .sync_n(sync_n), .blank_n(blank_n), .in_valid(in_valid));
    pvl_pixel_front i_dut (.clock(clock), .reset_n(reset_n), .pixel_index(pixel_index),
        .overlay_select(overlay_select), .sync_n(sync_n), .blank_n(blank_n),
        .pedestal_sel(pedestal_sel), .scale_50(scale_50), .sync_enable(sync_enable),
        .in_valid(in_valid), .in_ready(in_ready), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
        .out_valid(out_valid), .out_ready(out_ready), .red(red), .green(green), .blue(blue),
        .level(level), .iout_red(iout_red), .iout_green(iout_green), .iout_blue(iout_blue));
    // ********
    // Shared tasks
    // ********
    task stop_test();
        $display("checks %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : stop_test
    task tmo(input int k);
        if (k >= 20) begin
            n_fail++;
            stop_test();
        end
    endtask : tmo
    task do_reset();
        reset_n <= 1'b0;
        repeat (8) @(posedge clock);
        reset_n <= 1'b1;
    endtask : do_reset
    // Gap cycle after each strobe keeps one assignment per step
    task wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clock);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge clock);
        reg_write <= 1'b0;
    endtask : wr
    task rd(input logic [3:0] a, input logic [7:0] e);
        @(posedge clock);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge clock);
        reg_read <= 1'b0;
        #1;
        `CHK("rdata", e, reg_rdata)
    endtask : rd
    task wcol(input logic [3:0] base, input logic [7:0] a, input logic [23:0] c);
        wr(PVL_REG_ADDR, a);
        wr(base, c[23:16]);
        wr(base + 4'h1, c[15:8]);
        wr(base + 4'h2, c[7:0]);
    endtask : wcol
    task send(input logic [7:0] i, input logic [3:0] o, input logic s, input logic b);
        int k;
        @(posedge clock);
        px_idx     <= i;
        px_ovl     <= o;
        px_sync_n  <= s;
        px_blank_n <= b;
        req        <= 1'b1;
        for (k = 0; k < 20 && in_valid !== 1'b1; k++) @(posedge clock);
        req <= 1'b0;
        tmo(k);
    endtask : send
    task recv(input logic [23:0] c, input logic [4:0] l, input logic [11:0] cur);
        int k;
        for (k = 0; k < 20; k++) begin
            @(posedge clock);
            #1;
            if (out_valid === 1'b1) break;
        end
        tmo(k);
        `CHK("colour", c, {red, green, blue})
        `CHK("level", l, level)
        `CHK("current", cur, iout_red)
        `CHK("current g", (c[23:16] == c[15:8]) ? cur : lin75(c[15:8]), iout_green)
        `CHK("current b", (c[23:16] == c[7:0]) ? cur : lin75(c[7:0]), iout_blue)
        // Entry leaves at this edge when out_ready is high, so later strap changes meet an empty buffer
        @(posedge clock);
    endtask : recv
    task px(input logic [7:0] i, input logic [3:0] o, input logic s, input logic b,
            input logic [23:0] c, input logic [4:0] l, input logic [11:0] cur);
        send(i, o, s, b);
        recv(c, l, cur);
    endtask : px
    // ********
    // Scenarios
    // ********
    task t_setup();
        `CHK("in_ready", 1'b1, in_ready)
        `CHK("out_valid", 1'b0, out_valid)
        rd(PVL_REG_MASK, PVL_MASK_RST);
        wcol(PVL_REG_PAL_R, 8'h00, 24'h000000);
        wcol(PVL_REG_PAL_R, 8'h01, 24'hFFFFFF);
        wcol(PVL_REG_PAL_R, 8'h02, 24'h123456);
        wcol(PVL_REG_OVL_R, 8'h01, 24'hFFFFFF);
        rd(PVL_REG_PAL_R, 8'h00);
        rd(PVL_REG_ADDR, 8'h02);
        $display("t_setup done");
    endtask : t_setup
    task t_ped75();
        px(8'h01, 4'h0, 1, 1, 24'hFFFFFF, PVL_LVL_WHITE, PVL_I_WHITE_75S);
        px(8'h00, 4'h0, 1, 1, 24'h000000, PVL_LVL_BLACK, PVL_I_BLACK_75S);
        px(8'h01, 4'h1, 1, 0, 24'h000000, PVL_LVL_BLANK, PVL_I_BLANK_75);
        px(8'h01, 4'h0, 0, 0, 24'h000000, PVL_LVL_SYNC, 12'h000);
        bad_ok <= 1'b1;
        px(8'h00, 4'h0, 0, 1, 24'h000000, PVL_LVL_SYNC, 12'h08F);
        bad_ok <= 1'b0;
        $display("t_ped75 done");
    endtask : t_ped75
    task t_ped0();
        pedestal_sel <= 1'b0;
        px(8'h01, 4'h0, 1, 1, 24'hFFFFFF, PVL_LVL_WHITE, PVL_I_WHITE_75);
        px(8'h00, 4'h0, 1, 1, 24'h000000, PVL_LVL_BLACK, PVL_I_BLANK_75);
        px(8'h00, 4'h0, 1, 0, 24'h000000, PVL_LVL_BLANK, PVL_I_BLANK_75);
        px(8'h00, 4'h0, 0, 0, 24'h000000, PVL_LVL_SYNC, 12'h000);
        $display("t_ped0 done");
    endtask : t_ped0
    task t_s50();
        scale_50 <= 1'b1;
        px(8'h01, 4'h0, 1, 1, 24'hFFFFFF, PVL_LVL_WHITE, PVL_I_WHITE_50E);
        px(8'h00, 4'h0, 1, 0, 24'h000000, PVL_LVL_BLANK, PVL_I_BLANK_50);
        sync_enable <= 1'b0;
        px(8'h01, 4'h0, 1, 1, 24'hFFFFFF, PVL_LVL_WHITE, PVL_I_WHITE_50D);
        px(8'h00, 4'h0, 1, 1, 24'h000000, PVL_LVL_BLACK, 12'h000);
        scale_50 <= 1'b0;
        sync_enable <= 1'b1;
        pedestal_sel <= 1'b1;
        $display("t_s50 done");
    endtask : t_s50
    task t_stall();
        out_ready <= 1'b0;
        send(8'h01, 4'h0, 1, 1);
        send(8'h00, 4'h0, 1, 1);
        repeat (10) @(posedge clock);
        `CHK("in_ready full", 1'b0, in_ready)
        recv(24'hFFFFFF, PVL_LVL_WHITE, PVL_I_WHITE_75S);
        out_ready <= 1'b1;
        recv(24'h000000, PVL_LVL_BLACK, PVL_I_BLACK_75S);
        $display("t_stall done");
    endtask : t_stall
    task t_mask();
        px(8'h02, 4'h0, 1, 1, 24'h123456, PVL_LVL_DATA, I_D12);
        wr(PVL_REG_MASK, 8'hFE);
        px(8'h01, 4'h0, 1, 1, 24'h000000, PVL_LVL_BLACK, PVL_I_BLACK_75S);
        px(8'h00, 4'h1, 1, 1, 24'hFFFFFF, PVL_LVL_WHITE, PVL_I_WHITE_75S);
        do_reset();
        rd(PVL_REG_MASK, PVL_MASK_RST);
        $display("t_mask done");
    endtask : t_mask
    initial begin
        do_reset();
        t_setup();
        t_ped75();
        t_ped0();
        t_s50();
        t_stall();
        t_mask();
        stop_test();
    end
endmodule : pixel_input_video_level_select_tb

// ==== test/pvl_fb_model.sv ====
// Frame buffer model driving the pixel inputs
`timescale 1ns/10ps
module pvl_fb_model (
    input  wire logic       clock,
    input  wire logic       reset_n,
    input  wire logic       req,
    input  wire logic [7:0] px_idx,
    input  wire logic [3:0] px_ovl,
    input  wire logic       px_sync_n,
    input  wire logic       px_blank_n,
    input  wire logic       bad_ok,
    input  wire logic       in_ready,
    output logic      [7:0] pixel_index,
    output logic      [3:0] overlay_select,
    output logic            sync_n,
    output logic            blank_n,
    output logic            in_valid
);
    // ********
    // Pixel drive
    // ********
    // One cycle per pixel; idle lines toggle so stale values never match
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            in_valid       <= 1'b0;
            pixel_index    <= 8'h00;
            overlay_select <= 4'h0;
            sync_n         <= 1'b1;
            blank_n        <= 1'b1;
        end else if (req && !in_valid && in_ready) begin
            in_valid       <= 1'b1;
            pixel_index    <= px_idx;
            overlay_select <= px_ovl;
            blank_n        <= px_blank_n;
            sync_n         <= px_sync_n | (px_blank_n & ~bad_ok);
        end else begin
            in_valid       <= 1'b0;
            pixel_index    <= ~pixel_index;
            overlay_select <= ~overlay_select;
            sync_n         <= ~sync_n;
            blank_n        <= ~blank_n;
        end
    end
endmodule : pvl_fb_model

// ==== test/pvl_front_monitor.sv ====
// Checker of video levels and output stream
`timescale 1ns/10ps
module pvl_front_monitor
    import pvl_pkg::*;
(
    input wire logic                 clock,
    input wire logic                 reset_n,
    input wire logic                 pedestal_sel,
    input wire logic                 scale_50,
    input wire logic                 sync_enable,
    input wire logic                 in_ready,
    input wire logic                 out_valid,
    input wire logic                 out_ready,
    input wire logic [PVL_COL_W-1:0] red,
    input wire logic [PVL_COL_W-1:0] green,
    input wire logic [PVL_COL_W-1:0] blue,
    input wire logic [PVL_LVL_W-1:0] level,
    input wire logic [PVL_CUR_W-1:0] iout_red
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!reset_n);
    // ********
    // Assertions
    // ********
    reset_idle_a: assert property ($rose(reset_n) |-> !out_valid && in_ready)
        else $error("Output not idle after reset");
    blank_colour_a: assert property (out_valid && level == PVL_LVL_BLANK
        |-> {red, green, blue} == 24'h000000) else $error("Colour kept while blanked");
    blank_cur_a: assert property (out_valid && level == PVL_LVL_BLANK && pedestal_sel
        && !scale_50 |-> iout_red == PVL_I_BLANK_75) else $error("Wrong blank current");
    sync_cur_a: assert property (out_valid && level == PVL_LVL_SYNC && !pedestal_sel
        && !scale_50 && red == 8'h00 |-> iout_red == 12'h000) else $error("Sync not zero");
    white_cur_a: assert property (out_valid && level == PVL_LVL_WHITE && pedestal_sel
        && !scale_50 |-> iout_red == PVL_I_WHITE_75S) else $error("Wrong white current");
    black_off_a: assert property (out_valid && level == PVL_LVL_BLACK && scale_50
        && !sync_enable |-> iout_red == 12'h000) else $error("Black not zero");
    white_50_a: assert property (out_valid && level == PVL_LVL_WHITE && scale_50
        && sync_enable |-> iout_red == PVL_I_WHITE_50E) else $error("Wrong 50 ohm white");
    out_stand_a: assert property (out_valid && !out_ready |=> out_valid
        && $stable({red, green, blue}) && $stable(iout_red) && $stable(level))
        else $error("Output changed while stalled");
    // ********
    // Covers
    // ********
    stall_c: cover property (!in_ready);
    blank_c: cover property (out_valid && level == PVL_LVL_BLANK);
    sync_c: cover property (out_valid && level == PVL_LVL_SYNC);
endmodule : pvl_front_monitor

bind pvl_pixel_front pvl_front_monitor i_mon (.clock(clock), .reset_n(reset_n),
    .pedestal_sel(pedestal_sel), .scale_50(scale_50), .sync_enable(sync_enable),
    .in_ready(in_ready), .out_valid(out_valid), .out_ready(out_ready), .red(red),
    .green(green), .blue(blue), .level(level), .iout_red(iout_red));
